/* verification/test_vbs_slicer_regs.sv */
// self-checking bench of the slicer/status register bank
`timescale 1ns/1ps
`include "vbs_regs.svh"
module test_vbs_slicer_regs;
   localparam logic [6:0] SA = `VBS_SLAVE_ADDR;
   logic clk, arst_n, scl, sda_m, sda, sda_out, sda_oe_n, field_id;
   logic ck_hi, ck_lo, hunt, strict, ham_off, fis, ham_en, gate;
   logic [10:0] stat;
   logic [8:0] line_num;
   logic [3:0] ldt;
   logic [23:0] fc;
   logic [1:0] fcl;
   int error_cnt, checks;
   // open drain: with the slave released the wire follows the host's sda_m
   assign sda = sda_oe_n ? sda_m : sda_out;
   vbs_i2c_host i_vbs_i2c_host (.clk(clk), .sda_wire(sda), .scl(scl), .sda_m(sda_m));
   vbs_slicer_regs i_vbs_slicer_regs (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .capture_ready(stat[0]), .colour_match_seen(stat[1]), .copy_protect_seen(stat[2]),
      .slow_time_constant_on(stat[3]), .white_peak_active(stat[4]), .gain_at_min(stat[5]),
      .gain_at_max(stat[6]), .field_rate_flag(stat[7]), .hv_loop_unlocked(stat[8]),
      .hfreq_unlocked(stat[9]), .interlace_flag(stat[10]), .line_num(line_num), .field_id(field_id),
      .slicer_clk_sel_hi(ck_hi), .slicer_clk_sel_lo(ck_lo), .amplitude_search_stop(hunt),
      .strict_framing(strict), .parity_check_off(ham_off), .slicer_field_rate(fis), .line_data_type(ldt),
      .frame_code(fc), .frame_code_len(fcl), .hamming_check_en(ham_en), .vertical_gate_out(gate));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // compare and bus tasks
   // ----------------------------------------
   task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected byte at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_p(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected port at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic k0, k1, k2;
      i_vbs_i2c_host.start();
      i_vbs_i2c_host.xfer({SA, 1'b0}, 1'b1, q, k0);
      i_vbs_i2c_host.xfer(a, 1'b1, q, k1);
      i_vbs_i2c_host.xfer(d, 1'b1, q, k2);
      i_vbs_i2c_host.stop();
      chk_b({5'h0, k0, k1, k2}, 8'h00);
   endtask
   // read through a repeated start, ending with a host nack
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x, q;
      logic k0, k1, k2, k3;
      i_vbs_i2c_host.start();
      i_vbs_i2c_host.xfer({SA, 1'b0}, 1'b1, x, k0);
      i_vbs_i2c_host.xfer(a, 1'b1, x, k1);
      i_vbs_i2c_host.start();
      i_vbs_i2c_host.xfer({SA, 1'b1}, 1'b1, x, k2);
      i_vbs_i2c_host.xfer(8'hff, 1'b1, q, k3);
      i_vbs_i2c_host.stop();
      chk_b({5'h0, k0, k1, k2}, 8'h00);
      chk_b(q, e);
   endtask
   task automatic mv(input logic [8:0] n, input logic f);
      line_num <= n;
      field_id <= f;
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [7:0] st_exp(input logic [10:0] s, input logic l);
      return l ? {s[10:9], s[7:3], s[1]} : {s[10], s[8:4], s[2], s[0]};
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk_p({26'h0, ck_hi, ck_lo, hunt, strict, ham_off, fis}, 32'h10);
      rc(8'h40, 8'h02);
      rc(8'h41, 8'hff);
      rc(8'h57, 8'hff);
      rc(8'h3f, 8'h00);
   endtask
   task automatic t_status();
      logic [10:0] s;
      for (int m = 0; m < 4; m++) begin
         s = m[0] ? 11'h555 : 11'h2aa;
         stat <= s;
         wr(8'h13, {3'h0, m[1], 4'h0});
         rc(8'h1f, st_exp(s, m[1]));
      end
      wr(8'h1f, 8'h00);
      rc(8'h1f, st_exp(s, 1'b1));
   endtask
   task automatic t_lines();
      logic [23:0] f;
      logic [1:0] n;
      mv(9'd3, 1'b0);
      for (int c = 0; c < 16; c++) begin
         wr(8'h42, {c[3:0], c[3:0]});
         case (c)
            0, 4: {f, n} = {24'h27, 2'd1};
            1, 5: {f, n} = {24'h1, 2'd1};
            2: {f, n} = {24'h9951, 2'd2};
            3: {f, n} = {24'h1e3c1f, 2'd3};
            8, 9, 10, 13, 14: {f, n} = {24'h40, 2'd1};
            default: {f, n} = 26'h0;
         endcase
         chk_p({2'h0, ldt, fcl, fc}, {2'h0, c[3:0], n, f});
         chk_p({31'h0, ham_en}, {31'h0, c == 0 || c == 4 || c == 8 || c == 13});
      end
      wr(8'h42, 8'h23);
      chk_p({28'h0, ldt}, 32'h3);
      mv(9'd3, 1'b1);
      chk_p({28'h0, ldt}, 32'h2);
      wr(8'h5b, 8'h00);
      chk_p({28'h0, ldt}, 32'h3);
      wr(8'h57, 8'h5d);
      mv(9'd24, 1'b0);
      chk_p({28'h0, ldt}, 32'h5);
      mv(9'd25, 1'b0);
      chk_p({28'h0, ldt}, 32'hf);
   endtask
   task automatic t_gate();
      wr(8'h15, 8'h05);
      wr(8'h16, 8'h08);
      wr(8'h17, 8'h03);
      // line 0 matched both reset lines, so the gate may stand high; the stop line clears it
      mv(9'h108, 1'b0);
      chk_p({31'h0, gate}, 32'h0);
      mv(9'h005, 1'b0);
      chk_p({31'h0, gate}, 32'h0);
      mv(9'h105, 1'b0);
      chk_p({31'h0, gate}, 32'h1);
      mv(9'h008, 1'b0);
      chk_p({31'h0, gate}, 32'h1);
      mv(9'h108, 1'b0);
      chk_p({31'h0, gate}, 32'h0);
   endtask
   task automatic t_slicer();
      wr(8'h42, 8'h00);
      mv(9'd3, 1'b0);
      wr(8'h40, 8'ha2);
      chk_p({25'h0, ham_en, ck_hi, ck_lo, hunt, strict, ham_off, fis}, 32'h55);
      rc(8'h40, 8'ha2);
      wr(8'h40, 8'h52);
      chk_p({25'h0, ham_en, ck_hi, ck_lo, hunt, strict, ham_off, fis}, 32'h1a);
      wr(8'h40, 8'h02);
      chk_p({25'h0, ham_en, ck_hi, ck_lo, hunt, strict, ham_off, fis}, 32'h50);
   endtask
   task automatic summarize();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      error_cnt = 0;
      checks = 0;
      arst_n = 1'b0;
      stat = 11'h0;
      line_num = 9'h0;
      field_id = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_status();
      t_lines();
      t_gate();
      t_slicer();
      summarize();
   end
   // about 20k clk of traffic expected; three times that is a hang
   initial begin
      #3000000;
      error_cnt++;
      summarize();
   end
endmodule

/* verification/vbs_i2c_host.sv */
// i2c host model that configures and polls the slicer/status bank
`timescale 1ns/1ps
module vbs_i2c_host (
   input wire logic clk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // five clk per step keeps scl high 5 clk and low 10 clk, well above the slave's one-clk edge detection
   task automatic step(input logic s, input logic d);
      scl <= s;
      sda_m <= d;
      repeat (5) @(posedge clk);
   endtask
   // data changes only while scl is low, so no false start or stop
   task automatic bitx(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = sda_wire;
      step(1'b0, b);
   endtask
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(ai, ao);
   endtask
endmodule

/* verilog/vbs_pkg.sv */
// types shared by the slicer/status register bank
package vbs_pkg;
   typedef enum logic [3:0] {
      VBS_ST_IDLE = 4'h0,
      VBS_ST_ADDR = 4'h1,
      VBS_ST_AACK = 4'h2,
      VBS_ST_SUB = 4'h3,
      VBS_ST_SACK = 4'h4,
      VBS_ST_WR = 4'h5,
      VBS_ST_WACK = 4'h6,
      VBS_ST_RD = 4'h7,
      VBS_ST_RACK = 4'h8,
      VBS_ST_RNXT = 4'h9
   } vbs_state_e;

   typedef enum logic [3:0] {
      VBS_DT_EU_TT = 4'h0, VBS_DT_EU_CC = 4'h1,
      VBS_DT_VPS = 4'h2, VBS_DT_WIDE = 4'h3,
      VBS_DT_US_TT = 4'h4, VBS_DT_US_CC = 4'h5,
      VBS_DT_TEST = 4'h6, VBS_DT_OVS = 4'h7,
      VBS_DT_GTEXT = 4'h8, VBS_DT_EU_TC = 4'h9,
      VBS_DT_US_TC = 4'ha, VBS_DT_RSVD = 4'hb,
      VBS_DT_US_BTT = 4'hc, VBS_DT_JP_TXT = 4'hd,
      VBS_DT_JP_FS = 4'he, VBS_DT_ACTIVE = 4'hf
   } vbs_dtype_e;
endpackage

/* verilog/vbs_regs.svh */
// register offsets, field positions and reset values of the slicer/status bank
`ifndef VBS_REGS_SVH
`define VBS_REGS_SVH
// ------------------------------------------------------------
// subaddresses
// ------------------------------------------------------------
`define VBS_A_LEGACY 8'h13
`define VBS_A_GSTART 8'h15
`define VBS_A_GSTOP 8'h16
`define VBS_A_GMSB 8'h17
`define VBS_A_STATUS 8'h1f
`define VBS_A_SLICER 8'h40
`define VBS_A_LINE_FIRST 8'h41
`define VBS_A_LINE_LAST 8'h57
`define VBS_A_FRAMING 8'h58
`define VBS_A_FSWAP 8'h5b
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define VBS_B_LEGACY 4
`define VBS_B_START_MSB 0
`define VBS_B_STOP_MSB 1
`define VBS_B_CLK_LO 1
`define VBS_B_CLK_HI 2
`define VBS_B_HUNT 4
`define VBS_B_STRICT 5
`define VBS_B_HAM 6
`define VBS_B_FRATE 7
`define VBS_B_FSWAP 7
`define VBS_M_SLICER 8'hf6
// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define VBS_R_SLICER 8'h02
`define VBS_R_LINE 8'hff
`define VBS_R_FRAMING 8'h40
`define VBS_R_FSWAP 1'b1
`define VBS_R_GATE 8'h00
`define VBS_CLK_13M5 2'b01
`define VBS_FIRST_LINE 9'h002
`define VBS_LINES 23
// arbitrary bus address, not tied to any product
`define VBS_SLAVE_ADDR 7'h25
`define VBS_FC_TT 24'h000027
`define VBS_FC_CC 24'h000001
`define VBS_FC_VPS 24'h009951
`define VBS_FC_WIDE 24'h1e3c1f
`endif

/* verilog/vbs_slicer_regs.sv */
// slicer set-up and decoder status bank behind an i2c slave
`timescale 1ns/1ps
`include "vbs_regs.svh"

module vbs_slicer_regs
   import vbs_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = `VBS_SLAVE_ADDR,
   parameter int LINES = `VBS_LINES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic capture_ready,
   input wire logic colour_match_seen,
   input wire logic copy_protect_seen,
   input wire logic slow_time_constant_on,
   input wire logic white_peak_active,
   input wire logic gain_at_min,
   input wire logic gain_at_max,
   input wire logic field_rate_flag,
   input wire logic hv_loop_unlocked,
   input wire logic hfreq_unlocked,
   input wire logic interlace_flag,
   input wire logic [8:0] line_num,
   input wire logic field_id,
   output logic slicer_clk_sel_hi,
   output logic slicer_clk_sel_lo,
   output logic amplitude_search_stop,
   output logic strict_framing,
   output logic parity_check_off,
   output logic slicer_field_rate,
   output logic [3:0] line_data_type,
   output logic [23:0] frame_code,
   output logic [1:0] frame_code_len,
   output logic hamming_check_en,
   output logic vertical_gate_out
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_q;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   vbs_state_e st;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [3:0] bit_cnt;
   logic [7:0] shreg, tx, ptr, rd_data;
   logic rd_mode;
   logic wr_stb;
   logic [7:0] wr_addr, wr_data;
   logic [7:0] status;
   logic [7:0] slicer_control;
   logic [7:0] framing_code;
   logic [7:0] gate_start_lo, gate_stop_lo;
   logic gate_start_msb, gate_stop_msb;
   logic legacy_status_select;
   logic field_swap;
   logic [7:0] line_type_reg [LINES];
   logic [7:0] ptr_off;
   logic [8:0] line_off;
   logic in_table;
   logic use_hi;
   logic [3:0] next_type;
   logic [23:0] next_code;
   logic [1:0] next_len;
   logic next_ham;
   logic [8:0] gate_start, gate_stop;

   // ------------------------------------------------------------
   // i2c slave: address, subaddress, auto-incremented data
   // ------------------------------------------------------------
   assign scl_rise = scl & ~scl_q;
   assign scl_fall = ~scl & scl_q;
   assign bus_start = scl & scl_q & sda_q & ~sda_in;
   assign bus_stop = scl & scl_q & ~sda_q & sda_in;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   // the pin only ever pulls low; a one is sent by releasing it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= VBS_ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         rd_mode <= 1'b0;
         sda_oe_n <= 1'b1;
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (bus_start) begin
            st <= VBS_ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (bus_stop) begin
            st <= VBS_ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            unique case (st)
               VBS_ST_IDLE: begin
               end
               VBS_ST_ADDR, VBS_ST_SUB, VBS_ST_WR: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_in};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     sda_oe_n <= 1'b0;
                     if (st == VBS_ST_ADDR) begin
                        if (shreg[7:1] == SLAVE_ADDR) begin
                           rd_mode <= shreg[0];
                           st <= VBS_ST_AACK;
                        end else begin
                           sda_oe_n <= 1'b1;
                           st <= VBS_ST_IDLE;
                        end
                     end else if (st == VBS_ST_SUB) begin
                        ptr <= shreg;
                        st <= VBS_ST_SACK;
                     end else begin
                        wr_stb <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= shreg;
                        ptr <= ptr + 8'h01;
                        st <= VBS_ST_WACK;
                     end
                  end
               end
               VBS_ST_AACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (rd_mode) begin
                        tx <= rd_data;
                        sda_oe_n <= rd_data[7];
                        st <= VBS_ST_RD;
                     end else begin
                        sda_oe_n <= 1'b1;
                        st <= VBS_ST_SUB;
                     end
                  end
               end
               VBS_ST_SACK, VBS_ST_WACK: begin
                  if (scl_fall) begin
                     sda_oe_n <= 1'b1;
                     bit_cnt <= 4'h0;
                     st <= VBS_ST_WR;
                  end
               end
               VBS_ST_RD: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h7) begin
                        sda_oe_n <= 1'b1;
                        ptr <= ptr + 8'h01;
                        st <= VBS_ST_RACK;
                     end else begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe_n <= tx[6];
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               VBS_ST_RACK: begin
                  if (scl_rise) begin
                     st <= sda_in ? VBS_ST_IDLE : VBS_ST_RNXT;
                  end
               end
               VBS_ST_RNXT: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     tx <= rd_data;
                     sda_oe_n <= rd_data[7];
                     st <= VBS_ST_RD;
                  end
               end
               default: begin
                  st <= VBS_ST_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------
   // no case for the status address, so such writes fall away
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slicer_control <= `VBS_R_SLICER;
         framing_code <= `VBS_R_FRAMING;
         gate_start_lo <= `VBS_R_GATE;
         gate_stop_lo <= `VBS_R_GATE;
         gate_start_msb <= 1'b0;
         gate_stop_msb <= 1'b0;
         legacy_status_select <= 1'b0;
         field_swap <= `VBS_R_FSWAP;
      end else if (wr_stb) begin
         case (wr_addr)
            `VBS_A_SLICER: slicer_control <= wr_data & `VBS_M_SLICER;
            `VBS_A_FRAMING: framing_code <= wr_data;
            `VBS_A_GSTART: gate_start_lo <= wr_data;
            `VBS_A_GSTOP: gate_stop_lo <= wr_data;
            `VBS_A_GMSB: begin
               gate_start_msb <= wr_data[`VBS_B_START_MSB];
               gate_stop_msb <= wr_data[`VBS_B_STOP_MSB];
            end
            `VBS_A_LEGACY: legacy_status_select <= wr_data[`VBS_B_LEGACY];
            `VBS_A_FSWAP: field_swap <= wr_data[`VBS_B_FSWAP];
            default: begin
            end
         endcase
      end
   end

   // one table entry per video line, lines 2 to 24
   for (genvar i = 0; i < LINES; i++) begin : g_line
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            line_type_reg[i] <= `VBS_R_LINE;
         end else if (wr_stb && wr_addr == 8'(`VBS_A_LINE_FIRST + i)) begin
            line_type_reg[i] <= wr_data;
         end
      end
   end

   // reserved clock codes are stored as written; software must avoid them
   assign slicer_clk_sel_hi = slicer_control[`VBS_B_CLK_HI];
   assign slicer_clk_sel_lo = slicer_control[`VBS_B_CLK_LO];
   assign amplitude_search_stop = slicer_control[`VBS_B_HUNT];
   assign strict_framing = slicer_control[`VBS_B_STRICT];
   assign parity_check_off = slicer_control[`VBS_B_HAM];
   assign slicer_field_rate = slicer_control[`VBS_B_FRATE];

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   assign ptr_off = ptr - `VBS_A_LINE_FIRST;

   always_comb begin
      rd_data = 8'h00;
      if (ptr >= `VBS_A_LINE_FIRST && ptr <= `VBS_A_LINE_LAST) begin
         rd_data = line_type_reg[ptr_off[4:0]];
      end else begin
         case (ptr)
            `VBS_A_STATUS: rd_data = status;
            `VBS_A_SLICER: rd_data = slicer_control;
            `VBS_A_FRAMING: rd_data = framing_code;
            `VBS_A_GSTART: rd_data = gate_start_lo;
            `VBS_A_GSTOP: rd_data = gate_stop_lo;
            `VBS_A_GMSB: rd_data = {6'h00, gate_stop_msb, gate_start_msb};
            `VBS_A_LEGACY: rd_data = {3'h0, legacy_status_select, 4'h0};
            `VBS_A_FSWAP: rd_data = {field_swap, 7'h00};
            default: rd_data = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // status byte, refreshed every cycle from live conditions
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= 8'h00;
      end else begin
         status[0] <= legacy_status_select ? colour_match_seen : capture_ready;
         status[1] <= legacy_status_select ? slow_time_constant_on : copy_protect_seen;
         status[2] <= white_peak_active;
         status[3] <= gain_at_min;
         status[4] <= gain_at_max;
         status[5] <= field_rate_flag;
         status[6] <= legacy_status_select ? hfreq_unlocked : hv_loop_unlocked;
         status[7] <= interlace_flag;
      end
   end

   // ------------------------------------------------------------
   // per-line data type and framing selection
   // ------------------------------------------------------------
   assign line_off = line_num - `VBS_FIRST_LINE;
   assign in_table = (line_num >= `VBS_FIRST_LINE) && (line_off < 9'(LINES));
   // field_id low means field 1; the swap bit flips which nibble serves it
   assign use_hi = ~field_id ^ field_swap;

   always_comb begin
      next_type = 4'hf;
      next_code = 24'h000000;
      next_len = 2'h0;
      next_ham = 1'b0;
      if (in_table) begin
         next_type = use_hi ? line_type_reg[line_off[4:0]][7:4] : line_type_reg[line_off[4:0]][3:0];
      end
      unique case (vbs_dtype_e'(next_type))
         VBS_DT_EU_TT, VBS_DT_US_TT: begin
            next_code = `VBS_FC_TT;
            next_len = 2'h1;
            next_ham = ~parity_check_off;
         end
         VBS_DT_EU_CC, VBS_DT_US_CC: begin
            next_code = `VBS_FC_CC;
            next_len = 2'h1;
         end
         VBS_DT_VPS: begin
            next_code = `VBS_FC_VPS;
            next_len = 2'h2;
         end
         VBS_DT_WIDE: begin
            next_code = `VBS_FC_WIDE;
            next_len = 2'h3;
         end
         VBS_DT_GTEXT, VBS_DT_JP_TXT: begin
            next_code = {16'h0000, framing_code};
            next_len = 2'h1;
            next_ham = ~parity_check_off;
         end
         VBS_DT_EU_TC, VBS_DT_US_TC, VBS_DT_JP_FS: begin
            next_code = {16'h0000, framing_code};
            next_len = 2'h1;
         end
         // no framing code: test line, oversampled, reserved, broadcast text, active video
         VBS_DT_TEST, VBS_DT_OVS, VBS_DT_RSVD, VBS_DT_US_BTT, VBS_DT_ACTIVE: begin
            next_len = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_data_type <= 4'hf;
         frame_code <= 24'h000000;
         frame_code_len <= 2'h0;
         hamming_check_en <= 1'b0;
      end else begin
         line_data_type <= next_type;
         frame_code <= next_code;
         frame_code_len <= next_len;
         hamming_check_en <= next_ham;
      end
   end

   // ------------------------------------------------------------
   // vertical gate
   // ------------------------------------------------------------
   assign gate_start = {gate_start_msb, gate_start_lo};
   assign gate_stop = {gate_stop_msb, gate_stop_lo};

   // start wins if both lines are programmed equal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vertical_gate_out <= 1'b0;
      end else if (line_num == gate_start) begin
         vertical_gate_out <= 1'b1;
      end else if (line_num == gate_stop) begin
         vertical_gate_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_status_bit0:
   assert property (@(posedge clk) disable iff (!rst_n)
      ##1 status[0] == $past(legacy_status_select ? colour_match_seen : capture_ready))
      else $error("status bit 0 does not follow its source");
   chk_status_bit1:
   assert property (@(posedge clk) disable iff (!rst_n)
      !legacy_status_select ##1 !legacy_status_select |-> status[1] == $past(copy_protect_seen))
      else $error("status bit 1 lost copy protect flag");
   chk_status_lock:
   assert property (@(posedge clk) disable iff (!rst_n)
      legacy_status_select && hfreq_unlocked |=> status[6] || !$past(legacy_status_select))
      else $error("status bit 6 missed h unlock");
   chk_status_misc:
   assert property (@(posedge clk) disable iff (!rst_n)
      ##1 {status[7], status[5:2]} == $past({interlace_flag, field_rate_flag,
      gain_at_max, gain_at_min, white_peak_active}))
      else $error("status bits 2 to 5 or 7 wrong");
   chk_status_write_ignored:
   assert property (@(posedge clk) disable iff (!rst_n)
      wr_stb && wr_addr == `VBS_A_STATUS |=> $stable(slicer_control) && $stable(field_swap)
      && $stable(framing_code) && $stable(legacy_status_select) && $stable(gate_start_lo))
      else $error("status write changed a register");
   chk_clk_sel_reset:
   assert property (@(posedge clk) $rose(rst_n) |-> {slicer_clk_sel_hi, slicer_clk_sel_lo} == `VBS_CLK_13M5)
      else $error("clock select not 01 after reset");
   chk_line_field1:
   assert property (@(posedge clk) disable iff (!rst_n)
      in_table && !field_id && !field_swap |=> line_data_type == $past(line_type_reg[line_off[4:0]][7:4]))
      else $error("field 1 did not use upper nibble");
   chk_line_outside:
   assert property (@(posedge clk) disable iff (!rst_n)
      !in_table |=> line_data_type == 4'hf)
      else $error("line outside table not active video");
   chk_vps_code:
   assert property (@(posedge clk) disable iff (!rst_n)
      line_data_type == 4'h2 |-> frame_code == `VBS_FC_VPS && frame_code_len == 2'h2)
      else $error("vps framing code wrong");
   chk_hamming_off:
   assert property (@(posedge clk) disable iff (!rst_n)
      parity_check_off |=> !hamming_check_en)
      else $error("hamming check while disabled");
   chk_gate_rise:
   assert property (@(posedge clk) disable iff (!rst_n)
      line_num == gate_start |=> vertical_gate_out)
      else $error("gate did not rise at start line");
endmodule
